// file: hdl/focr_fault_response.sv
`timescale 1ns/1ps
// Notes on behaviour
// - any fast overcurrent fault sets a sticky status bit and notifies host
// - response 00: keep running at normal current limit, never shut down
// - response 11: run at fast limit for the programmed delay
// - delay over and still limiting: shut down, apply retry field
// - retry 000: no restart, output off until fault cleared
// - retry 001..101: restart one to five times, count equals code
// - all permitted restarts failed: output off until fault cleared
// - restart starts spaced by delay field in the current fault unit
// - retry 111: restart without limit
// - retry 110: up to six restarts, then off until cleared
// - delay field d means two to the power d time units
// - unit field codes 00..11 select 1, 4, 16, 256 ms
// - retrying stops on command off, bias loss or other fault
module focr_fault_response
  import focr_pkg::*;
#(
  parameter int unsigned P_CYC_PER_MS = FOCR_CYC_PER_MS
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_cmd_wr,
  input  wire logic [7:0] i_cmd_code,
  input  wire logic [7:0] i_cmd_wdata,
  input  wire logic       i_fault_clear,
  input  wire logic       i_fast_fault,
  input  wire logic       i_in_limit,
  input  wire logic       i_off_cmd,
  input  wire logic       i_bias_ok,
  input  wire logic       i_other_fault,
  output logic [7:0]      o_cmd_rdata,
  output logic            o_output_en,
  output logic            o_fast_limit,
  output logic            o_fault_status,
  output logic            o_host_notify
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       fault_prev_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      sync1_q      <= 5'h00;
      sync2_q      <= 5'h00;
      fault_prev_q <= 1'b0;
    end else begin
      sync1_q      <= {i_other_fault, i_bias_ok, i_off_cmd,
                       i_in_limit, i_fast_fault};
      sync2_q      <= sync1_q;
      fault_prev_q <= sync2_q[0];
    end
  end

  wire logic fault_s    = sync2_q[0];
  wire logic limit_s    = sync2_q[1];
  wire logic stop_s     = sync2_q[2] | ~sync2_q[3] | sync2_q[4];
  wire logic fault_rise = fault_s & ~fault_prev_q;

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  focr_cfg_s  cfg_q;
  focr_cfg_s  cfg_d;
  logic [7:0] fcfg_q;
  logic [7:0] fcfg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    cfg_d   = cfg_q;
    fcfg_d  = fcfg_q;
    if (i_cmd_wr && i_cmd_code == FOCR_CMD_ACTION) begin
      cfg_d = focr_cfg_s'(i_cmd_wdata);
    end
    if (i_cmd_wr && i_cmd_code == FOCR_CMD_FAULT_CFG) begin
      fcfg_d = i_cmd_wdata;
    end
    case (i_cmd_code)
      FOCR_CMD_ACTION:    rdata_d = cfg_q;
      FOCR_CMD_FAULT_CFG: rdata_d = fcfg_q;
      default:            rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cfg_q   <= focr_cfg_s'(FOCR_ACTION_RST);
      fcfg_q  <= FOCR_FAULT_CFG_RST;
      rdata_q <= 8'h00;
    end else begin
      cfg_q   <= cfg_d;
      fcfg_q  <= fcfg_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // delay length
  // ---------------------------------------------------------------
  logic [3:0]  unit_shift;
  logic [31:0] delay_cyc;

  always_comb begin
    case (fcfg_q[FOCR_UNIT_LSB +: 2])
      2'h0:    unit_shift = FOCR_UNIT_SHIFT0;
      2'h1:    unit_shift = FOCR_UNIT_SHIFT1;
      2'h2:    unit_shift = FOCR_UNIT_SHIFT2;
      default: unit_shift = FOCR_UNIT_SHIFT3;
    endcase
    // worst case 256 ms * 128 fits 32 bits at the default clock
    delay_cyc = P_CYC_PER_MS[31:0]
                << (unit_shift + {1'b0, cfg_q.delay});
  end

  // ---------------------------------------------------------------
  // response state machine
  // ---------------------------------------------------------------
  focr_state_e state_q;
  focr_state_e state_d;
  logic [31:0] tmr_q;
  logic [31:0] tmr_d;
  logic [2:0]  tries_q;
  logic [2:0]  tries_d;
  logic        status_q;
  logic        status_d;
  logic        notify_q;
  logic        notify_d;
  logic        outen_q;
  logic        outen_d;
  logic        fastlim_q;
  logic        fastlim_d;

  wire logic   shut_mode = (cfg_q.resp == FOCR_RESP_SHUTDOWN);
  wire logic   exhausted = (cfg_q.retry == FOCR_RETRY_NONE) ||
                           (cfg_q.retry != FOCR_RETRY_FOREVER &&
                            tries_q >= cfg_q.retry);

  always_comb begin
    state_d   = state_q;
    tmr_d     = tmr_q;
    tries_d   = tries_q;
    notify_d  = fault_rise;
    // set wins over a clear in the same cycle
    status_d  = fault_rise | (status_q & ~i_fault_clear);
    fastlim_d = shut_mode;
    case (state_q)
      FOCR_RUN: begin
        if (fault_s && shut_mode) begin
          state_d = FOCR_LIMIT;
          tmr_d   = delay_cyc;
        end
      end
      FOCR_LIMIT: begin
        if (!shut_mode) begin
          state_d = FOCR_RUN;
        end else if (tmr_q > 32'h1) begin
          tmr_d = tmr_q - 32'h1;
        end else if (limit_s) begin
          state_d = FOCR_OFFWAIT;
          tmr_d   = delay_cyc;
        end else begin
          state_d = FOCR_RUN;
        end
      end
      FOCR_OFFWAIT: begin
        if (exhausted) begin
          state_d = FOCR_LATCHED;
        end else if (tmr_q > 32'h1) begin
          tmr_d = tmr_q - 32'h1;
        end else begin
          state_d = FOCR_RUN;
          if (cfg_q.retry != FOCR_RETRY_FOREVER) begin
            tries_d = tries_q + 3'h1;
          end
        end
      end
      FOCR_LATCHED: begin
        if (i_fault_clear) begin
          state_d = FOCR_RUN;
          tries_d = 3'h0;
        end
      end
      FOCR_HALT: state_d = FOCR_RUN; // the stop override below holds it
      default: state_d = FOCR_RUN;
    endcase
    if (stop_s) begin
      state_d = FOCR_HALT;
      tries_d = 3'h0;
    end
    outen_d = (state_d == FOCR_RUN) || (state_d == FOCR_LIMIT);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_q   <= FOCR_HALT;
      tmr_q     <= 32'h0;
      tries_q   <= 3'h0;
      status_q  <= 1'b0;
      notify_q  <= 1'b0;
      outen_q   <= 1'b0;
      fastlim_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      tmr_q     <= tmr_d;
      tries_q   <= tries_d;
      status_q  <= status_d;
      notify_q  <= notify_d;
      outen_q   <= outen_d;
      fastlim_q <= fastlim_d;
    end
  end

  assign o_cmd_rdata    = rdata_q;
  assign o_output_en    = outen_q;
  assign o_fast_limit   = fastlim_q;
  assign o_fault_status = status_q;
  assign o_host_notify  = notify_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  property p_status_set;
    fault_rise |=> o_fault_status && o_host_notify;
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("fault edge did not set status and notify");
  property p_no_shut_ignore;
    (!shut_mode && state_q == FOCR_RUN && !stop_s) |=> state_q == FOCR_RUN;
  endproperty
  a_no_shut_ignore: assert property (p_no_shut_ignore)
    else $error("run left with non-shutdown response");
  property p_fast_sel;
    $changed(cfg_q.resp) |=> o_fast_limit == $past(shut_mode);
  endproperty
  a_fast_sel: assert property (p_fast_sel)
    else $error("fast limit select does not follow response");
  property p_limit_load;
    (state_q == FOCR_RUN && fault_s && shut_mode && !stop_s)
      |=> state_q == FOCR_LIMIT && tmr_q == $past(delay_cyc);
  endproperty
  a_limit_load: assert property (p_limit_load)
    else $error("limit delay not loaded");
  property p_shutdown;
    (state_q == FOCR_LIMIT && tmr_q <= 32'h1 && limit_s && shut_mode
     && !stop_s) |=> state_q == FOCR_OFFWAIT && !o_output_en;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("no shutdown after delay while limiting");
  property p_no_retry;
    (state_q == FOCR_OFFWAIT && cfg_q.retry == FOCR_RETRY_NONE && !stop_s)
      |=> state_q == FOCR_LATCHED;
  endproperty
  a_no_retry: assert property (p_no_retry)
    else $error("restart attempted with retry zero");
  property p_tries_cap;
    cfg_q.retry != FOCR_RETRY_FOREVER && $stable(cfg_q.retry)
      |-> tries_q <= cfg_q.retry;
  endproperty
  a_tries_cap: assert property (p_tries_cap)
    else $error("restart count above retry setting");
  property p_latched_off;
    state_q == FOCR_LATCHED && !i_fault_clear && !stop_s
      |=> state_q == FOCR_LATCHED && !o_output_en;
  endproperty
  a_latched_off: assert property (p_latched_off)
    else $error("latched off left without clear");
  property p_forever;
    (state_q == FOCR_OFFWAIT && cfg_q.retry == FOCR_RETRY_FOREVER
     && $stable(cfg_q.retry)) |=> state_q != FOCR_LATCHED;
  endproperty
  a_forever: assert property (p_forever)
    else $error("continuous retry stopped");
  property p_stop;
    stop_s |=> state_q == FOCR_HALT && !o_output_en;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop condition ignored");

  c_shutdown: cover property (state_q == FOCR_LIMIT ##1
                              state_q == FOCR_OFFWAIT);
  c_restart:  cover property (state_q == FOCR_OFFWAIT ##1
                              state_q == FOCR_RUN);
  c_latched:  cover property (state_q == FOCR_LATCHED ##1
                              state_q == FOCR_RUN);

endmodule : focr_fault_response

// file: hdl/focr_pkg.sv
package focr_pkg;

  // ---------------------------------------------------------------
  // command codes and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FOCR_CMD_ACTION    = 8'hca;
  localparam logic [7:0] FOCR_CMD_FAULT_CFG = 8'hc8;
  localparam logic [7:0] FOCR_ACTION_RST    = 8'h00;
  localparam logic [7:0] FOCR_FAULT_CFG_RST = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FOCR_RESP_LSB  = 6;
  localparam int FOCR_RETRY_LSB = 3;
  localparam int FOCR_DELAY_LSB = 0;
  localparam int FOCR_UNIT_LSB  = 2;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] FOCR_RESP_IGNORE   = 2'h0;
  localparam logic [1:0] FOCR_RESP_SHUTDOWN = 2'h3;
  localparam logic [2:0] FOCR_RETRY_NONE    = 3'h0;
  localparam logic [2:0] FOCR_RETRY_FOREVER = 3'h7;

  // unit codes 0..3 give 1, 4, 16, 256 ms as a left shift
  localparam logic [3:0] FOCR_UNIT_SHIFT0 = 4'h0;
  localparam logic [3:0] FOCR_UNIT_SHIFT1 = 4'h2;
  localparam logic [3:0] FOCR_UNIT_SHIFT2 = 4'h4;
  localparam logic [3:0] FOCR_UNIT_SHIFT3 = 4'h8;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned FOCR_CLK_PERIOD_NS = 100;
  localparam int unsigned FOCR_MS_NS         = 1000000;
  localparam int unsigned FOCR_CYC_PER_MS    =
    FOCR_MS_NS / FOCR_CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } focr_cfg_s;

  typedef enum logic [2:0] {
    FOCR_RUN     = 3'b000,
    FOCR_LIMIT   = 3'b001,
    FOCR_OFFWAIT = 3'b010,
    FOCR_LATCHED = 3'b011,
    FOCR_HALT    = 3'b100
  } focr_state_e;

endpackage : focr_pkg

// file: verification/focr_host_model.sv
`timescale 1ns/1ps
// host side of the command port: one byte per write, read back one edge late
module focr_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_cmd_rdata,
  output logic            o_cmd_wr,
  output logic [7:0]      o_cmd_code,
  output logic [7:0]      o_cmd_wdata
);
  initial begin
    o_cmd_wr    = 1'b0;
    o_cmd_code  = 8'h00;
    o_cmd_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge i_sys_clk);
    o_cmd_wr    <= 1'b1;
    o_cmd_code  <= code;
    o_cmd_wdata <= data;
    @(posedge i_sys_clk);
    o_cmd_wr    <= 1'b0;
    // data lines released: show garbage, not the last value
    o_cmd_wdata <= ~data;
  endtask : wr

  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    @(posedge i_sys_clk);
    o_cmd_code <= code;
    repeat (2) @(posedge i_sys_clk);
    #1 data = i_cmd_rdata;
  endtask : rd
endmodule : focr_host_model

// file: verification/focr_fault_response_bench.sv
`timescale 1ns/1ps
module focr_fault_response_bench;
  import focr_pkg::*;
  localparam int unsigned CPM = 4;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       fault = 1'b0;
  logic       lim = 1'b0;
  logic       off = 1'b0;
  logic       bias = 1'b1;
  logic       other = 1'b0;
  logic       clr = 1'b0;
  logic       wr_s;
  logic [7:0] code_s;
  logic [7:0] wdata_s;
  logic [7:0] rdata;
  logic       o_en;
  logic       o_fl;
  logic       o_st;
  logic       o_nt;
  int         err_total = 0;
  int         num_checks = 0;
  int         cyc = 0;
  logic [7:0] rv;
  int         n;

  focr_fault_response #(.P_CYC_PER_MS(CPM)) u_focr_fault_response (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_cmd_wr(wr_s),
    .i_cmd_code(code_s), .i_cmd_wdata(wdata_s), .i_fault_clear(clr),
    .i_fast_fault(fault), .i_in_limit(lim), .i_off_cmd(off),
    .i_bias_ok(bias), .i_other_fault(other), .o_cmd_rdata(rdata),
    .o_output_en(o_en), .o_fast_limit(o_fl), .o_fault_status(o_st),
    .o_host_notify(o_nt));

  focr_host_model u_focr_host_model (
    .i_sys_clk(clk), .i_cmd_rdata(rdata), .o_cmd_wr(wr_s),
    .o_cmd_code(code_s), .o_cmd_wdata(wdata_s));

  always #50 clk = ~clk;

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // bounded wait; n returns the cycles it took
  task automatic wait_en(input logic v, input int lmt);
    n = 0;
    while (o_en !== v && n < lmt) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_en

  task automatic clear_all();
    @(posedge clk);
    fault <= 1'b0;
    lim   <= 1'b0;
    // let the pin synchronisers drain, or a stale fault relimits
    repeat (3) @(posedge clk);
    clr   <= 1'b1;
    @(posedge clk);
    clr   <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check("status_cleared", {7'h0, o_st}, 8'h00);
    wait_en(1'b1, 10);
    check("en_after_clear", {7'h0, o_en}, 8'h01);
  endtask : clear_all

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    u_focr_host_model.rd(FOCR_CMD_ACTION, rv);
    check("action_reset", rv, FOCR_ACTION_RST);
    u_focr_host_model.wr(FOCR_CMD_ACTION, 8'hc9);
    u_focr_host_model.wr(8'h00, 8'h55);
    u_focr_host_model.rd(FOCR_CMD_ACTION, rv);
    check("action_rw", rv, 8'hc9);
    u_focr_host_model.rd(8'h00, rv);
    check("unmapped_read", rv, 8'h00);
    u_focr_host_model.rd(FOCR_CMD_FAULT_CFG, rv);
    check("unit_reset", rv, FOCR_FAULT_CFG_RST);
    $display("test regs done");
  endtask : t_regs

  // non-shutdown codes, reserved ones included
  task automatic t_ignore(input logic [1:0] resp);
    u_focr_host_model.wr(FOCR_CMD_ACTION, {resp, 6'h00});
    @(posedge clk);
    fault <= 1'b1;
    lim   <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("notify", {7'h0, o_nt}, 8'h01);
    check("status", {7'h0, o_st}, 8'h01);
    repeat (300) @(posedge clk);
    #1 check("en_kept", {7'h0, o_en}, 8'h01);
    check("normal_limit", {7'h0, o_fl}, 8'h00);
    clear_all();
    $display("test ignore %h done", resp);
  endtask : t_ignore

  task automatic t_shut(input logic [1:0] unit, input logic [2:0] d);
    int mul[4] = '{1, 4, 16, 256};
    int expn;
    expn = CPM * mul[unit] * (1 << d);
    u_focr_host_model.wr(FOCR_CMD_FAULT_CFG, {4'h0, unit, 2'h0});
    u_focr_host_model.wr(FOCR_CMD_ACTION, {2'b11, 3'b000, d});
    @(posedge clk);
    fault <= 1'b1;
    lim   <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("fast_limit", {7'h0, o_fl}, 8'h01);
    wait_en(1'b0, expn + 20);
    check("delay_ok", 8'((n >= expn) && (n <= expn + 2)), 8'h01);
    repeat (300) @(posedge clk);
    #1 check("no_retry", {7'h0, o_en}, 8'h00);
    clear_all();
    $display("test shutdown unit %h delay %h done", unit, d);
  endtask : t_shut

  task automatic t_retry(input logic [2:0] code);
    int tries;
    tries = (code == FOCR_RETRY_FOREVER) ? 8 : int'(code);
    u_focr_host_model.wr(FOCR_CMD_FAULT_CFG, 8'h00);
    u_focr_host_model.wr(FOCR_CMD_ACTION, {2'b11, code, 3'h0});
    lim <= 1'b1;
    for (int k = 0; k <= tries; k++) begin
      @(posedge clk);
      fault <= 1'b1;
      wait_en(1'b0, 30);
      @(posedge clk);
      fault <= 1'b0;
      wait_en(1'b1, 30);
      if (k < tries || code == FOCR_RETRY_FOREVER)
        check("restart_gap", 8'(n >= CPM - 2 && n <= CPM), 8'h01);
      else
        check("latched_off", {7'h0, o_en}, 8'h00);
    end
    @(posedge clk);
    off <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check("off_cmd_stop", {7'h0, o_en}, 8'h00);
    @(posedge clk);
    off <= 1'b0;
    clear_all();
    $display("test retry %h done", code);
  endtask : t_retry

  // bias loss and another fault stop the output as well
  task automatic t_stop();
    @(posedge clk);
    bias <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check("bias_stop", {7'h0, o_en}, 8'h00);
    @(posedge clk);
    bias  <= 1'b1;
    other <= 1'b1;
    repeat (6) @(posedge clk);
    #1 check("other_stop", {7'h0, o_en}, 8'h00);
    @(posedge clk);
    other <= 1'b0;
    wait_en(1'b1, 10);
    check("stop_release", {7'h0, o_en}, 8'h01);
    $display("test stop done");
  endtask : t_stop

  // ---------------------------------------------------------------
  // sequence and verdict
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    wait_en(1'b1, 10);
    check("en_after_reset", {7'h0, o_en}, 8'h01);
    t_regs();
    for (int r = 0; r < 3; r++) t_ignore(2'(r));
    t_shut(2'h1, 3'h1);
    t_shut(2'h3, 3'h0);
    t_shut(2'h0, 3'h7);
    t_shut(2'h2, 3'h2);
    for (int c = 1; c < 8; c++) t_retry(3'(c));
    t_stop();
    results();
  end
endmodule : focr_fault_response_bench
